/* File: pct_pkg.sv */
// shared types and constants for the pipeline cycle-timing sequencer
// assumes a single core clock and an upstream decoder that fills issue_t
package pct_pkg;

   localparam int REG_W    = 4;
   localparam int LIST_W   = 16;
   localparam int CNT_W    = 6;
   localparam int NSRC     = 3;

   // multiplier operand field positions
   localparam int MUL_RS_LSB = 8;
   localparam int MUL_RS_MSB = 11;
   localparam int CMP_RS_MSB = 2;
   localparam int TERM_LO    = 8;
   localparam int TERM_MID   = 16;
   localparam int TERM_HI    = 24;

   localparam logic [REG_W-1:0] PC_REG = 4'hf;

   // cycle counts
   localparam logic [CNT_W-1:0] LEN_BASE       = 6'h01;
   localparam logic [CNT_W-1:0] LEN_PC_REFILL  = 6'h02;
   localparam logic [CNT_W-1:0] LEN_BRANCH     = 6'h03;
   localparam logic [CNT_W-1:0] LEN_LOAD_PC    = 6'h05;
   localparam logic [CNT_W-1:0] LEN_ONE_REG    = 6'h02;
   localparam logic [CNT_W-1:0] LEN_LDM_PC_ADD = 6'h04;
   localparam logic [CNT_W-1:0] LEN_SWAP       = 6'h02;
   localparam logic [CNT_W-1:0] LEN_MRC_PC_ADD = 6'h02;
   localparam logic [CNT_W-1:0] LEN_MSR_FULL   = 6'h03;
   localparam logic [CNT_W-1:0] LEN_MUL_BASE   = 6'h02;
   localparam logic [CNT_W-1:0] LEN_MULL_BASE  = 6'h03;
   localparam logic [CNT_W-1:0] IL_WORD        = 6'h01;
   localparam logic [CNT_W-1:0] IL_SUB         = 6'h02;

   // early-termination multiplier counts
   localparam logic [2:0] M_ONE   = 3'h1;
   localparam logic [2:0] M_TWO   = 3'h2;
   localparam logic [2:0] M_THREE = 3'h3;
   localparam logic [2:0] M_FOUR  = 3'h4;

   typedef enum logic [1:0] {CYC_IDLE, CYC_SEQ, CYC_NSEQ, CYC_CPX} pct_cyc_t;

   typedef enum logic [3:0] {
      CLS_DP, CLS_BRANCH, CLS_LOAD, CLS_STORE, CLS_LDM, CLS_STM,
      CLS_SWAP, CLS_CDP, CLS_CP_MEM, CLS_MCR, CLS_MRC, CLS_MRS,
      CLS_MSR, CLS_MUL, CLS_MULL
   } pct_cls_t;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} pct_state_t;

   typedef struct packed {
      pct_cls_t               cls;
      logic                   pc_dest;
      logic                   reg_shift;
      logic                   sub_word;
      logic                   flags_only;
      logic                   unsigned_mul;
      logic [REG_W-1:0]       dst;
      logic [LIST_W-1:0]      reg_list;
      logic [4:0]             cp_words;
   } pct_issue_t;

   typedef struct packed {
      logic                   valid;
      logic [NSRC-1:0]        src_en;
      logic [NSRC-1:0][REG_W-1:0] src;
   } pct_next_t;

endpackage : pct_pkg

/* File: pct_mul_term.sv */
// multiplier operand selection and early-termination cycle count
// assumes the register file returns the selected operand combinationally
`timescale 1ns/1ps
module pct_mul_term (
   // instruction being issued
   input  wire logic [31:0] instr_word,
   input  wire logic        compressed_mode,
   input  wire logic        unsigned_mul,
   // register file
   output logic [3:0]       opnd_idx,
   input  wire logic [31:0] opnd,
   // result
   output logic [2:0]       m_cycles
);

   logic hi8;
   logic hi16;
   logic hi24;

   always_comb
   begin
      if (compressed_mode)
         opnd_idx = {1'b0, instr_word[pct_pkg::CMP_RS_MSB:0]};
      else
         opnd_idx = instr_word[pct_pkg::MUL_RS_MSB:pct_pkg::MUL_RS_LSB];
   end

   // unsigned forms only terminate on leading zeros
   always_comb
   begin
      hi8  = ~|opnd[31:pct_pkg::TERM_LO];
      hi16 = ~|opnd[31:pct_pkg::TERM_MID];
      hi24 = ~|opnd[31:pct_pkg::TERM_HI];
      if (!unsigned_mul)
      begin
         hi8  = hi8  | (&opnd[31:pct_pkg::TERM_LO]);
         hi16 = hi16 | (&opnd[31:pct_pkg::TERM_MID]);
         hi24 = hi24 | (&opnd[31:pct_pkg::TERM_HI]);
      end
   end

   always_comb
   begin
      if (hi8)
         m_cycles = pct_pkg::M_ONE;
      else if (hi16)
         m_cycles = pct_pkg::M_TWO;
      else if (hi24)
         m_cycles = pct_pkg::M_THREE;
      else
         m_cycles = pct_pkg::M_FOUR;
   end

endmodule : pct_mul_term

/* File: pct_sequencer.sv */
// per-instruction cycle sequencer: announces instruction and data bus
// cycle types, interlock stalls and multi-register transfer order
// assumes the decoder presents the next instruction's sources at issue
`timescale 1ns/1ps

// What this block does
// - plain data op: one cycle, fetch S
// - register shift adds one idle cycle
// - pc write: S,N,S refill, shift adds one
// - single load: one cycle, one N access
// - word load-use: one interlock cycle
// - subword load-use: two interlock cycles
// - load to pc: five cycles, fixed pattern
// - one-register multi load: two cycles
// - n-register multi load: N then S
// - multi load with pc: n+4 cycles
// - multi store: 1N+1I or 1N+(n-1)S
// - swap: two N, byte use adds one
// - coprocessor busy stretches by b cycles
// - register transfer ends on C cycle
// - status write: flags one, else three
// - multiply 2+m, long multiply 3+m
// - signed m from sign-uniform upper bits
// - unsigned m from zero upper bits
// - operand register from instruction field
// - no fetches during interlock cycles
// - multi load lowest register first
// - last-register dependency adds one cycle
module pct_sequencer (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // instruction issue
   input  wire logic                  issue_valid,
   output logic                       issue_ready,
   input  wire pct_pkg::pct_issue_t   issue,
   input  wire logic [31:0]           instr_word,
   input  wire logic                  compressed_mode,
   // sources of the following instruction
   input  wire pct_pkg::pct_next_t    next_use,
   // multiplier operand read port
   output logic [3:0]                 mul_opnd_idx,
   input  wire logic [31:0]           mul_opnd,
   // coprocessor
   input  wire logic                  cp_busy,
   // bus cycle announcements
   output pct_pkg::pct_cyc_t          ibus_cyc,
   output pct_pkg::pct_cyc_t          dbus_cyc,
   output logic                       ifetch_req,
   output logic                       dbus_req,
   output logic [3:0]                 xfer_reg,
   output logic                       stall,
   output logic                       done
);

   localparam int CW = pct_pkg::CNT_W;

   pct_pkg::pct_state_t st_r;
   pct_pkg::pct_issue_t iss_r;
   logic [CW-1:0]       k_r;
   logic [CW-1:0]       len_r;
   logic [CW-1:0]       il_r;
   logic [CW-1:0]       n_r;
   logic                redirect_r;
   logic                busy_seen_r;
   logic [15:0]         list_r;

   logic [CW-1:0]       len_nxt;
   logic [CW-1:0]       il_nxt;
   logic [CW-1:0]       n_nxt;
   logic [CW-1:0]       pop;
   logic [CW-1:0]       m6;
   logic [CW-1:0]       last_k;
   logic [CW-1:0]       prev_k;
   logic [3:0]          hi_reg;
   logic [2:0]          mul_m;
   logic [2:0]          hit_dst;
   logic [2:0]          hit_hi;
   logic                dep;
   logic                uses_hi;
   logic                accept;
   logic                run_now;
   logic                busy_now;
   logic                last;
   logic                is_cp;
   logic                pc_in_list;
   logic                redirect_nxt;
   logic                xfer_act;

   pct_mul_term u_mul_term (
      .instr_word      (instr_word),
      .compressed_mode (compressed_mode),
      .unsigned_mul    (issue.unsigned_mul),
      .opnd_idx        (mul_opnd_idx),
      .opnd            (mul_opnd),
      .m_cycles        (mul_m)
   );

   assign m6 = {3'h0, mul_m};
   assign pc_in_list = issue.reg_list[pct_pkg::PC_REG];

   // register list size and highest listed register
   always_comb
   begin
      pop    = '0;
      hi_reg = '0;
      for (int i = 0; i < pct_pkg::LIST_W; i++)
      begin
         if (issue.reg_list[i])
         begin
            pop    = pop + 6'h01;
            hi_reg = 4'(i);
         end
      end
   end

   // compare the pending destination against each source of the follower
   for (genvar g = 0; g < pct_pkg::NSRC; g++)
   begin : g_src
      assign hit_dst[g] = next_use.valid && next_use.src_en[g] &&
                          next_use.src[g] == issue.dst;
      assign hit_hi[g]  = next_use.valid && next_use.src_en[g] &&
                          next_use.src[g] == hi_reg;
   end

   assign dep     = |hit_dst;
   assign uses_hi = |hit_hi;

   // interlock cycles owed by the issuing instruction
   always_comb
   begin
      il_nxt = '0;
      case (issue.cls)
         pct_pkg::CLS_LOAD:
            if (!issue.pc_dest && dep)
               il_nxt = issue.sub_word ? pct_pkg::IL_SUB
                                       : pct_pkg::IL_WORD;
         pct_pkg::CLS_SWAP:
            if (dep && issue.sub_word)
               il_nxt = pct_pkg::IL_WORD;
         pct_pkg::CLS_LDM:
            if (!pc_in_list && uses_hi)
               il_nxt = pct_pkg::IL_WORD;
         pct_pkg::CLS_MRC:
            if (!issue.pc_dest && dep)
               il_nxt = pct_pkg::IL_WORD;
         default:
            il_nxt = '0;
      endcase
   end

   // run length, excluding coprocessor busy-wait cycles
   always_comb
   begin
      n_nxt = pop;
      unique case (issue.cls)
         pct_pkg::CLS_DP:
            len_nxt = pct_pkg::LEN_BASE
                    + (issue.reg_shift ? 6'h01 : 6'h00)
                    + (issue.pc_dest ? pct_pkg::LEN_PC_REFILL
                                     : 6'h00);
         pct_pkg::CLS_BRANCH:
            len_nxt = pct_pkg::LEN_BRANCH;
         pct_pkg::CLS_LOAD:
            len_nxt = issue.pc_dest ? pct_pkg::LEN_LOAD_PC
                                    : pct_pkg::LEN_BASE + il_nxt;
         pct_pkg::CLS_STORE:
            len_nxt = pct_pkg::LEN_BASE;
         pct_pkg::CLS_LDM:
            if (pc_in_list)
               len_nxt = pop + pct_pkg::LEN_LDM_PC_ADD;
            else if (pop == 6'h01)
               len_nxt = pct_pkg::LEN_ONE_REG + il_nxt;
            else
               len_nxt = pop + il_nxt;
         pct_pkg::CLS_STM:
            len_nxt = (pop == 6'h01) ? pct_pkg::LEN_ONE_REG : pop;
         pct_pkg::CLS_SWAP:
            len_nxt = pct_pkg::LEN_SWAP + il_nxt;
         pct_pkg::CLS_CDP:
            len_nxt = pct_pkg::LEN_BASE;
         pct_pkg::CLS_CP_MEM:
         begin
            n_nxt   = {1'b0, issue.cp_words};
            len_nxt = {1'b0, issue.cp_words};
         end
         pct_pkg::CLS_MCR:
            len_nxt = pct_pkg::LEN_BASE;
         pct_pkg::CLS_MRC:
            len_nxt = pct_pkg::LEN_BASE
                    + (issue.pc_dest ? pct_pkg::LEN_MRC_PC_ADD
                                     : il_nxt);
         pct_pkg::CLS_MRS:
            len_nxt = pct_pkg::LEN_BASE;
         pct_pkg::CLS_MSR:
            len_nxt = issue.flags_only ? pct_pkg::LEN_BASE
                                       : pct_pkg::LEN_MSR_FULL;
         pct_pkg::CLS_MUL:
            len_nxt = pct_pkg::LEN_MUL_BASE + m6;
         pct_pkg::CLS_MULL:
            len_nxt = pct_pkg::LEN_MULL_BASE + m6;
         default:
            len_nxt = pct_pkg::LEN_BASE;
      endcase
   end

   // classes that refill the pipeline end on an N then S fetch
   assign redirect_nxt = (issue.cls == pct_pkg::CLS_DP && issue.pc_dest) ||
                         issue.cls == pct_pkg::CLS_BRANCH ||
                         (issue.cls == pct_pkg::CLS_LOAD && issue.pc_dest) ||
                         (issue.cls == pct_pkg::CLS_LDM && pc_in_list);

   assign is_cp = issue.cls == pct_pkg::CLS_CDP ||
                  issue.cls == pct_pkg::CLS_CP_MEM ||
                  issue.cls == pct_pkg::CLS_MCR ||
                  issue.cls == pct_pkg::CLS_MRC;

   assign busy_now    = st_r == pct_pkg::ST_WAIT && cp_busy;
   assign run_now     = st_r == pct_pkg::ST_RUN ||
                        (st_r == pct_pkg::ST_WAIT && !cp_busy);
   assign last_k      = len_r - 6'h01;
   assign prev_k      = len_r - 6'h02;
   assign last        = run_now && k_r == last_k;
   assign issue_ready = st_r == pct_pkg::ST_IDLE || last;
   assign accept      = issue_valid && issue_ready;
   assign done        = last;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         st_r <= pct_pkg::ST_IDLE;
      else if (accept)
         st_r <= is_cp ? pct_pkg::ST_WAIT : pct_pkg::ST_RUN;
      else if (last)
         st_r <= pct_pkg::ST_IDLE;
      else if (run_now)
         st_r <= pct_pkg::ST_RUN;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         k_r <= '0;
      else if (accept)
         k_r <= '0;
      else if (run_now)
         k_r <= k_r + 6'h01;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         busy_seen_r <= 1'b0;
      else if (accept)
         busy_seen_r <= 1'b0;
      else if (busy_now)
         busy_seen_r <= 1'b1;
   end

   // instruction context held for the whole sequence
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         iss_r      <= '0;
         len_r      <= pct_pkg::LEN_BASE;
         il_r       <= '0;
         n_r        <= '0;
         redirect_r <= 1'b0;
      end
      else if (accept)
      begin
         iss_r      <= issue;
         len_r      <= len_nxt;
         il_r       <= il_nxt;
         n_r        <= n_nxt;
         redirect_r <= redirect_nxt;
      end
   end

   // remaining registers; the lowest set bit is the next transfer
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         list_r <= '0;
      else if (accept)
         list_r <= issue.reg_list;
      else if (xfer_act)
         list_r <= list_r & (list_r - 16'h0001);
   end

   always_comb
   begin
      xfer_reg = '0;
      for (int i = pct_pkg::LIST_W - 1; i >= 0; i--)
      begin
         if (list_r[i])
            xfer_reg = 4'(i);
      end
   end

   // per-cycle bus announcements
   always_comb
   begin
      ibus_cyc = pct_pkg::CYC_IDLE;
      dbus_cyc = pct_pkg::CYC_IDLE;
      stall    = 1'b0;
      if (busy_now)
         ibus_cyc = busy_seen_r ? pct_pkg::CYC_IDLE : pct_pkg::CYC_SEQ;
      else if (run_now)
      begin
         if (k_r == '0 && !busy_seen_r)
            ibus_cyc = pct_pkg::CYC_SEQ;
         if (redirect_r && k_r == last_k)
            ibus_cyc = pct_pkg::CYC_SEQ;
         else if (redirect_r && k_r == prev_k)
            ibus_cyc = pct_pkg::CYC_NSEQ;
         case (iss_r.cls)
            pct_pkg::CLS_LOAD:
               if (k_r == '0)
                  dbus_cyc = pct_pkg::CYC_NSEQ;
            pct_pkg::CLS_STORE:
               dbus_cyc = pct_pkg::CYC_NSEQ;
            pct_pkg::CLS_SWAP:
               if (k_r < 6'h02)
                  dbus_cyc = pct_pkg::CYC_NSEQ;
            pct_pkg::CLS_LDM, pct_pkg::CLS_STM, pct_pkg::CLS_CP_MEM:
               if (iss_r.cls == pct_pkg::CLS_LDM && n_r == 6'h01 &&
                   !redirect_r)
               begin
                  if (k_r == '0)
                     dbus_cyc = pct_pkg::CYC_SEQ;
               end
               else if (k_r == '0)
                  dbus_cyc = pct_pkg::CYC_NSEQ;
               else if (k_r < n_r)
                  dbus_cyc = pct_pkg::CYC_SEQ;
            pct_pkg::CLS_MCR, pct_pkg::CLS_MRC:
               if (k_r == last_k)
                  dbus_cyc = pct_pkg::CYC_CPX;
            default:
               dbus_cyc = pct_pkg::CYC_IDLE;
         endcase
         if (il_r != '0)
         begin
            if (iss_r.cls == pct_pkg::CLS_MRC)
               stall = k_r == last_k;
            else
               stall = k_r >= len_r - il_r;
         end
         if (stall)
            ibus_cyc = pct_pkg::CYC_IDLE;
      end
   end

   assign ifetch_req = ibus_cyc != pct_pkg::CYC_IDLE;
   assign dbus_req   = dbus_cyc != pct_pkg::CYC_IDLE;
   assign xfer_act   = dbus_req && (iss_r.cls == pct_pkg::CLS_LDM ||
                                    iss_r.cls == pct_pkg::CLS_STM);

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_refill;
      ibus_cyc == pct_pkg::CYC_IDLE [*2] ##1
      ibus_cyc == pct_pkg::CYC_NSEQ ##1
      (ibus_cyc == pct_pkg::CYC_SEQ && done);
   endsequence

   sequence s_word_use;
      accept && issue.cls == pct_pkg::CLS_LOAD && !issue.pc_dest &&
      dep && !issue.sub_word;
   endsequence

   sequence s_sub_use;
      accept && issue.cls == pct_pkg::CLS_LOAD && !issue.pc_dest &&
      dep && issue.sub_word;
   endsequence

   a_dp_single: assert property (
      accept && issue.cls == pct_pkg::CLS_DP && !issue.pc_dest &&
      !issue.reg_shift |=> ibus_cyc == pct_pkg::CYC_SEQ &&
      dbus_cyc == pct_pkg::CYC_IDLE && done)
      else $error("plain data op not single cycle");

   a_load_word_use: assert property (
      s_word_use |=> (dbus_cyc == pct_pkg::CYC_NSEQ && !stall) ##1
      (stall && done && dbus_cyc == pct_pkg::CYC_IDLE))
      else $error("word load-use interlock wrong");

   a_load_sub_use: assert property (
      s_sub_use |=> dbus_cyc == pct_pkg::CYC_NSEQ ##1
      (stall && !done) ##1 (stall && done))
      else $error("subword load-use interlock wrong");

   a_load_pc_seq: assert property (
      accept && issue.cls == pct_pkg::CLS_LOAD && issue.pc_dest |=>
      (ibus_cyc == pct_pkg::CYC_SEQ && dbus_cyc == pct_pkg::CYC_NSEQ)
      ##1 s_refill)
      else $error("load to pc sequence wrong");

   a_stall_no_fetch: assert property (
      stall |-> !ifetch_req && (done || !issue_ready))
      else $error("fetch during interlock");

   a_ldm_ascend: assert property (
      xfer_act && k_r != '0 && $past(xfer_act) |->
      xfer_reg > $past(xfer_reg))
      else $error("multi transfer order not ascending");

   a_ldm_last_dep: assert property (
      accept && issue.cls == pct_pkg::CLS_LDM &&
      issue.reg_list == 16'h000e && uses_hi |=>
      !done [*3] ##1 (done && stall))
      else $error("last-register dependency not stalled");

   a_cp_wait: assert property (
      busy_now |-> dbus_cyc == pct_pkg::CYC_IDLE && !done)
      else $error("coprocessor busy cycle not idle");

   a_msr_full: assert property (
      accept && issue.cls == pct_pkg::CLS_MSR && !issue.flags_only |=>
      !done [*2] ##1 done)
      else $error("full status write not three cycles");

   a_mul_short: assert property (
      accept && issue.cls == pct_pkg::CLS_MUL && !issue.unsigned_mul &&
      &mul_opnd[31:8] |=> !done [*2] ##1 done)
      else $error("multiply early termination wrong");

   a_umul_long: assert property (
      accept && issue.cls == pct_pkg::CLS_MULL && issue.unsigned_mul &&
      mul_opnd[31:24] != 8'h00 |=> !done [*6] ##1 done)
      else $error("unsigned long multiply count wrong");

endmodule : pct_sequencer

/* File: pct_mem_model.sv */
// far-side model: register file read port and coprocessor busy-wait
// assumes the bench sets busy_cnt before issuing a coprocessor op
`timescale 1ns/1ps
module pct_mem_model (
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   // issue seen by the sequencer
   input  wire logic                issue_valid,
   input  wire logic                issue_ready,
   input  wire pct_pkg::pct_issue_t issue,
   input  wire logic [3:0]          busy_cnt,
   // register file and coprocessor
   input  wire logic [3:0]          mul_opnd_idx,
   output logic [31:0]              mul_opnd,
   output logic                     cp_busy
);
   logic [3:0] busy_r;
   // busy for busy_cnt cycles right after the accept edge
   always_ff @(posedge core_clk)
      if (!rst_n)
         busy_r <= 4'h0;
      else if (issue_valid && issue_ready && issue.cls inside
               {pct_pkg::CLS_CDP, pct_pkg::CLS_CP_MEM,
                pct_pkg::CLS_MCR, pct_pkg::CLS_MRC})
         busy_r <= busy_cnt;
      else if (busy_r != 4'h0)
         busy_r <= busy_r - 4'h1;
   assign cp_busy = busy_r != 4'h0;
   // distinct values so a wrong index changes the multiply length
   always_comb
      case (mul_opnd_idx)
         4'h5:    mul_opnd = 32'hffff_ff80;
         4'h3:    mul_opnd = 32'h0000_1234;
         default: mul_opnd = 32'h7fff_ffff;
      endcase
endmodule : pct_mem_model

/* File: test_pct_sequencer.sv */
// bench for the cycle sequencer: counts bus cycle kinds per instruction
// assumes pct_mem_model stands in for register file and coprocessor
`timescale 1ns/1ps
module test_pct_sequencer;
   logic                core_clk = 1'b0;
   logic                rst_n = 1'b0;
   logic                issue_valid = 1'b0;
   logic                issue_ready;
   pct_pkg::pct_issue_t issue = '0;
   logic [31:0]         instr_word = 32'h0000_0000;
   logic                compressed_mode = 1'b0;
   pct_pkg::pct_next_t  next_use = '0;
   logic [3:0]          mul_opnd_idx;
   logic [31:0]         mul_opnd;
   logic                cp_busy;
   logic [3:0]          busy_cnt = 4'h0;
   pct_pkg::pct_cyc_t   ibus_cyc;
   pct_pkg::pct_cyc_t   dbus_cyc;
   logic                ifetch_req;
   logic                dbus_req;
   logic [3:0]          xfer_reg;
   logic                stall;
   logic                done;
   logic [3:0]          fx;
   logic [3:0]          lx;
   int                  fail_count = 0;
   int                  checked = 0;

   always #12.5 core_clk = ~core_clk;

   pct_sequencer DUT (.core_clk(core_clk), .rst_n(rst_n),
      .issue_valid(issue_valid), .issue_ready(issue_ready),
      .issue(issue), .instr_word(instr_word),
      .compressed_mode(compressed_mode), .next_use(next_use),
      .mul_opnd_idx(mul_opnd_idx), .mul_opnd(mul_opnd),
      .cp_busy(cp_busy), .ibus_cyc(ibus_cyc), .dbus_cyc(dbus_cyc),
      .ifetch_req(ifetch_req), .dbus_req(dbus_req),
      .xfer_reg(xfer_reg), .stall(stall), .done(done));
   pct_mem_model u_mem (.core_clk(core_clk), .rst_n(rst_n),
      .issue_valid(issue_valid), .issue_ready(issue_ready),
      .issue(issue), .busy_cnt(busy_cnt), .mul_opnd_idx(mul_opnd_idx),
      .mul_opnd(mul_opnd), .cp_busy(cp_busy));

   task automatic chk(string n, logic [23:0] e, logic [23:0] s);
      checked++;
      if (e !== s)
      begin
         $display("BAD %s exp %h seen %h", n, e, s);
         fail_count++;
      end
   endtask : chk

   // f = pc_dest,reg_shift,sub_word,flags_only,unsigned_mul
   // u[4] set: next instruction reads register u[3:0]
   // e nibbles: length, ibus S, ibus N, dbus N, dbus S, stalls
   task automatic run(pct_pkg::pct_cls_t c, logic [4:0] f,
                      logic [15:0] l, logic [4:0] u, logic [23:0] e);
      logic [23:0] s;
      int          k;
      s = '0;
      k = 0;
      issue.cls = c;
      {issue.pc_dest, issue.reg_shift, issue.sub_word, issue.flags_only,
       issue.unsigned_mul} = f;
      issue.dst = 4'h2;
      issue.reg_list = l;
      issue.cp_words = 5'h02;
      next_use.valid = 1'b1;
      next_use.src_en = {2'b00, u[4]};
      next_use.src[0] = u[3:0];
      issue_valid = 1'b1;
      @(posedge core_clk) #1;
      issue_valid = 1'b0;
      do
      begin
         @(negedge core_clk);
         k++;
         s += 24'h10_0000;
         if (ibus_cyc === pct_pkg::CYC_SEQ) s += 24'h01_0000;
         if (ibus_cyc === pct_pkg::CYC_NSEQ) s += 24'h00_1000;
         if (dbus_cyc === pct_pkg::CYC_NSEQ) s += 24'h00_0100;
         if (dbus_cyc === pct_pkg::CYC_SEQ) s += 24'h00_0010;
         if (stall === 1'b1) s += 24'h00_0001;
         if (stall === 1'b1 && ifetch_req !== 1'b0)
            chk("fetch_in_stall", 24'h0, 24'h1);
         if (issue_ready !== done)
            chk("ready", 24'(done), 24'(issue_ready));
         if (done === 1'b1 && c inside {pct_pkg::CLS_MCR, pct_pkg::CLS_MRC})
            chk("c_cycle", 24'(pct_pkg::CYC_CPX), 24'(dbus_cyc));
         if (dbus_req === 1'b1 && k == 1) fx = xfer_reg;
         if (dbus_req === 1'b1) lx = xfer_reg;
      end
      while (done !== 1'b1 && k < 30);
      // leave just after an edge so callers drive on the same phase
      @(posedge core_clk) #1;
      chk(c.name(), e, s);
   endtask : run

   task automatic t_dp;
      run(pct_pkg::CLS_DP, 5'h00, 16'h0, 5'h00, 24'h11_0000);
      run(pct_pkg::CLS_DP, 5'h08, 16'h0, 5'h00, 24'h21_0000);
      run(pct_pkg::CLS_DP, 5'h18, 16'h0, 5'h00, 24'h42_1000);
      run(pct_pkg::CLS_DP, 5'h10, 16'h0, 5'h00, 24'h32_1000);
   endtask : t_dp

   task automatic t_load;
      run(pct_pkg::CLS_LOAD, 5'h00, 16'h0, 5'h12, 24'h21_0101);
      run(pct_pkg::CLS_LOAD, 5'h00, 16'h0, 5'h13, 24'h11_0100);
      run(pct_pkg::CLS_LOAD, 5'h04, 16'h0, 5'h12, 24'h31_0102);
      run(pct_pkg::CLS_LOAD, 5'h10, 16'h0, 5'h00, 24'h52_1100);
   endtask : t_load

   task automatic t_multi;
      run(pct_pkg::CLS_LDM, 5'h00, 16'h000e, 5'h00, 24'h31_0120);
      chk("xfer_order", 24'h13, {16'h0, fx, lx});
      run(pct_pkg::CLS_LDM, 5'h00, 16'h000e, 5'h13, 24'h41_0121);
      run(pct_pkg::CLS_LDM, 5'h00, 16'h000e, 5'h11, 24'h31_0120);
      run(pct_pkg::CLS_LDM, 5'h00, 16'h0002, 5'h00, 24'h21_0010);
      run(pct_pkg::CLS_LDM, 5'h10, 16'h8002, 5'h00, 24'h62_1110);
      run(pct_pkg::CLS_STM, 5'h00, 16'h0002, 5'h00, 24'h21_0100);
      run(pct_pkg::CLS_STM, 5'h00, 16'h000e, 5'h00, 24'h31_0120);
   endtask : t_multi

   task automatic t_swap;
      run(pct_pkg::CLS_SWAP, 5'h00, 16'h0, 5'h12, 24'h21_0200);
      run(pct_pkg::CLS_SWAP, 5'h04, 16'h0, 5'h12, 24'h31_0201);
   endtask : t_swap

   task automatic t_cp;
      busy_cnt = 4'h2;
      run(pct_pkg::CLS_CDP, 5'h00, 16'h0, 5'h00, 24'h31_0000);
      busy_cnt = 4'h1;
      run(pct_pkg::CLS_CP_MEM, 5'h00, 16'h0, 5'h00, 24'h31_0110);
      run(pct_pkg::CLS_MRC, 5'h00, 16'h0, 5'h12, 24'h31_0001);
      busy_cnt = 4'h0;
      run(pct_pkg::CLS_MCR, 5'h00, 16'h0, 5'h00, 24'h11_0000);
   endtask : t_cp

   task automatic t_msr_mul;
      run(pct_pkg::CLS_MSR, 5'h02, 16'h0, 5'h00, 24'h11_0000);
      run(pct_pkg::CLS_MSR, 5'h00, 16'h0, 5'h00, 24'h31_0000);
      instr_word = 32'h0000_0500;
      run(pct_pkg::CLS_MUL, 5'h00, 16'h0, 5'h00, 24'h31_0000);
      run(pct_pkg::CLS_MULL, 5'h01, 16'h0, 5'h00, 24'h71_0000);
      run(pct_pkg::CLS_MULL, 5'h00, 16'h0, 5'h00, 24'h41_0000);
      compressed_mode = 1'b1;
      instr_word = 32'h0000_0f03;
      run(pct_pkg::CLS_MUL, 5'h00, 16'h0, 5'h00, 24'h41_0000);
   endtask : t_msr_mul

   task automatic end_of_test;
      if (fail_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   // whole run is well under 1000 cycles
   initial
   begin
      #(25 * 4000);
      fail_count++;
      end_of_test();
   end

   initial
   begin
      next_use.src[1] = 4'h9;
      next_use.src[2] = 4'h9;
      repeat (16) @(posedge core_clk);
      #1 rst_n = 1'b1;
      t_dp();
      t_load();
      t_multi();
      t_swap();
      t_cp();
      t_msr_mul();
      end_of_test();
   end
endmodule : test_pct_sequencer
